/* rtl/tsp_tone_prog.sv */
// Tone status word, configuration load port and their serial register access
`timescale 1ns/1ps
`default_nettype none
module tsp_tone_prog #(
    parameter int PROG_CYCLES = tsp_pkg::PROG_CYCLES,
    parameter logic [4:0] INB_UNRECOG = 5'h1F
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic ser_clk,
    input wire logic ser_csel_n,
    input wire logic ser_din,
    output logic ser_dout,
    output logic ser_dout_oe_n,
    input wire logic [5:0] sub_tone_idx,
    input wire logic [2:0] sub_cond,
    input wire logic [4:0] inband_idx,
    input wire logic ctcss_en,
    input wire logic dcs_en,
    input wire logic ext_tone_en,
    input wire logic inband_en,
    input wire logic rx_mode,
    input wire logic tx_mode,
    input wire logic sp_enable,
    input wire logic xtal_off,
    input wire logic prog_retain,
    output logic prog_ready,
    output logic ctcss_evt,
    output logic dcs_evt,
    output logic inband_evt,
    output logic [15:0] frame_sync_pattern,
    output logic [15:0] bit_sync_pattern,
    output logic [6:0] tone_len_ms,
    output logic inband_deemph_en
);
    // One busy cycle would let ready return before the host can see it drop
    if (PROG_CYCLES < 2 || PROG_CYCLES > 8191) begin : g_chk
        $error("PROG_CYCLES out of range");
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // DCS family codes; their changes count as DCS events
    function automatic logic is_dcs(input logic [2:0] c);
        is_dcs = (c == tsp_pkg::COND_DCS) || (c == tsp_pkg::COND_DCS_INV) || (c == tsp_pkg::COND_TURNOFF);
    endfunction

    function automatic logic [6:0] tone_len(input logic [1:0] code);
        case (code)
            2'h0: tone_len = tsp_pkg::TLEN_0;
            2'h1: tone_len = tsp_pkg::TLEN_1;
            2'h2: tone_len = tsp_pkg::TLEN_2;
            default: tone_len = tsp_pkg::TLEN_3;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; edge detection reads only the second stage onward
    logic clk_s1_ff, clk_s2_ff, clk_s3_ff, cs_s1_ff, cs_s2_ff, din_s1_ff, din_s2_ff;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            clk_s1_ff <= 1'b0;
            clk_s2_ff <= 1'b0;
            clk_s3_ff <= 1'b0;
            cs_s1_ff <= 1'b1;
            cs_s2_ff <= 1'b1;
            din_s1_ff <= 1'b0;
            din_s2_ff <= 1'b0;
        end else begin
            clk_s1_ff <= ser_clk;
            clk_s2_ff <= clk_s1_ff;
            clk_s3_ff <= clk_s2_ff;
            cs_s1_ff <= ser_csel_n;
            cs_s2_ff <= cs_s1_ff;
            din_s1_ff <= ser_din;
            din_s2_ff <= din_s1_ff;
        end
    end
    wire logic sclk_rise = clk_s2_ff & ~clk_s3_ff;
    wire logic sclk_fall = ~clk_s2_ff & clk_s3_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Tone status word and change events
    logic [15:0] word_ff, nxt_word;
    logic ctcss_evt_ff, nxt_ctcss_evt, dcs_evt_ff, nxt_dcs_evt, inband_evt_ff, nxt_inband_evt;
    logic [5:0] sub_v;
    logic [2:0] cond_v;
    logic [4:0] inb_v;
    logic sub_chg, inb_chg, cond_chg;
    always_comb begin
        // sub-audio index; code 55 passes through untouched
        sub_v = ctcss_en ? sub_tone_idx : tsp_pkg::SUB_NONE;
        inb_v = inband_en ? inband_idx : tsp_pkg::INB_NONE;
        // condition codes, reserved and disabled read none
        case (sub_cond)
            tsp_pkg::COND_DCS, tsp_pkg::COND_DCS_INV, tsp_pkg::COND_TURNOFF: cond_v = dcs_en ? sub_cond : tsp_pkg::COND_NONE;
            tsp_pkg::COND_EXT: cond_v = ext_tone_en ? sub_cond : tsp_pkg::COND_NONE;
            default: cond_v = tsp_pkg::COND_NONE;
        endcase
        // special condition blanks the low byte
        if (cond_v != tsp_pkg::COND_NONE) begin
            sub_v = tsp_pkg::SUB_NONE;
        end
        // in-band index on top; transmit zeroes all
        nxt_word = tx_mode ? 16'h0000 : {inb_v, cond_v, 2'b00, sub_v};
        // all sub index changes but none-to-invalid
        sub_chg = (nxt_word[tsp_pkg::SUB_LSB +: 6] != word_ff[tsp_pkg::SUB_LSB +: 6])
            && !(word_ff[tsp_pkg::SUB_LSB +: 6] == tsp_pkg::SUB_NONE
            && nxt_word[tsp_pkg::SUB_LSB +: 6] == tsp_pkg::SUB_INVALID);
        inb_chg = (nxt_word[tsp_pkg::INB_LSB +: 5] != word_ff[tsp_pkg::INB_LSB +: 5])
            && !((nxt_word[tsp_pkg::INB_LSB +: 5] | word_ff[tsp_pkg::INB_LSB +: 5]) == INB_UNRECOG
            && (nxt_word[tsp_pkg::INB_LSB +: 5] == tsp_pkg::INB_NONE
            || word_ff[tsp_pkg::INB_LSB +: 5] == tsp_pkg::INB_NONE));
        cond_chg = nxt_word[tsp_pkg::COND_LSB +: 3] != word_ff[tsp_pkg::COND_LSB +: 3];
        // DCS loss, turn-off and recovery are DCS events
        nxt_dcs_evt = !tx_mode && cond_chg
            && (is_dcs(nxt_word[tsp_pkg::COND_LSB +: 3]) || is_dcs(word_ff[tsp_pkg::COND_LSB +: 3]));
        nxt_ctcss_evt = !tx_mode && (sub_chg || (cond_chg && !nxt_dcs_evt));
        nxt_inband_evt = !tx_mode && inb_chg;
    end

    // Events are one-cycle pulses in their own flops, registered beside the status word
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            word_ff <= 16'h0000;
            ctcss_evt_ff <= 1'b0;
            dcs_evt_ff <= 1'b0;
            inband_evt_ff <= 1'b0;
        end else begin
            word_ff <= nxt_word;
            ctcss_evt_ff <= nxt_ctcss_evt;
            dcs_evt_ff <= nxt_dcs_evt;
            inband_evt_ff <= nxt_inband_evt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial slave: address byte then 16 data bits, MSB first
    logic [4:0] bcnt_ff, nxt_bcnt;
    logic [7:0] addr_ff, nxt_addr;
    logic [15:0] sh_ff, nxt_sh, wr_data_ff, nxt_wr_data;
    logic dout_ff, nxt_dout, oe_n_ff, nxt_oe_n, wr_stb_ff, nxt_wr_stb;
    always_comb begin
        nxt_bcnt = bcnt_ff;
        nxt_addr = addr_ff;
        nxt_sh = sh_ff;
        nxt_dout = dout_ff;
        nxt_oe_n = oe_n_ff;
        nxt_wr_stb = 1'b0;
        nxt_wr_data = wr_data_ff;
        if (cs_s2_ff) begin
            nxt_bcnt = 5'h00;
            nxt_oe_n = 1'b1;
        end else if (sclk_rise && bcnt_ff != tsp_pkg::END_BITS) begin
            nxt_bcnt = bcnt_ff + 5'h01;
            if (bcnt_ff < tsp_pkg::ADDR_BITS) begin
                nxt_addr = {addr_ff[6:0], din_s2_ff};
                // Snapshot keeps the read word coherent across 16 bits
                if (bcnt_ff == tsp_pkg::ADDR_BITS - 5'h01 && nxt_addr == tsp_pkg::TONE_OFS) begin
                    nxt_sh = word_ff;
                    nxt_dout = word_ff[15];
                    nxt_oe_n = 1'b0;
                end
            end else if (addr_ff == tsp_pkg::PROG_OFS) begin
                nxt_sh = {sh_ff[14:0], din_s2_ff};
                if (bcnt_ff == tsp_pkg::LAST_BIT) begin
                    nxt_wr_stb = 1'b1;
                    nxt_wr_data = nxt_sh;
                end
            end
        end else if (sclk_fall && addr_ff == tsp_pkg::TONE_OFS
                     && bcnt_ff >= tsp_pkg::FIRST_OUT && bcnt_ff <= tsp_pkg::LAST_BIT) begin
            nxt_sh = {sh_ff[14:0], 1'b0};
            nxt_dout = sh_ff[14];
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            bcnt_ff <= 5'h00;
            addr_ff <= 8'h00;
            sh_ff <= 16'h0000;
            dout_ff <= 1'b0;
            oe_n_ff <= 1'b1;
            wr_stb_ff <= 1'b0;
            wr_data_ff <= 16'h0000;
        end else begin
            bcnt_ff <= nxt_bcnt;
            addr_ff <= nxt_addr;
            sh_ff <= nxt_sh;
            dout_ff <= nxt_dout;
            oe_n_ff <= nxt_oe_n;
            wr_stb_ff <= nxt_wr_stb;
            wr_data_ff <= nxt_wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration store and programming handshake
    logic [13:0] mem_ff [0:31];
    logic [13:0] nxt_mem [0:31];
    logic prog_ready_ff, nxt_prog_ready, sp_d_ff;
    logic [tsp_pkg::BUSY_W-1:0] busy_ff, nxt_busy;
    logic [3:0] ptr_ff, nxt_ptr;
    logic [15:0] fs_ff, bs_ff;
    logic [6:0] tlen_ff;
    logic deemph_ff;
    logic [1:0] blk;
    logic [3:0] limit;
    logic [13:0] data;
    // writes out of turn are dropped, not queued
    wire logic wr_ok = wr_stb_ff && prog_ready_ff && sp_enable && !xtal_off && !rx_mode && !tx_mode;
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            nxt_mem[i] = mem_ff[i];
        end
        nxt_prog_ready = prog_ready_ff;
        nxt_busy = busy_ff;
        nxt_ptr = ptr_ff;
        blk = wr_data_ff[tsp_pkg::BLK_SEL_BIT] ? wr_data_ff[13:12] : tsp_pkg::BLK4_SLOT;
        data = wr_data_ff[tsp_pkg::BLK_SEL_BIT] ? {2'b00, wr_data_ff[11:0]} : wr_data_ff[13:0];
        case (wr_data_ff[tsp_pkg::BLK_SEL_BIT] ? {1'b0, blk} : 3'h4)
            3'h0: limit = tsp_pkg::B0_WORDS;
            3'h1: limit = tsp_pkg::B1_WORDS;
            3'h2: limit = tsp_pkg::B2_WORDS;
            3'h4: limit = tsp_pkg::B4_WORDS;
            default: limit = 4'h0;
        endcase
        if (busy_ff != '0) begin
            nxt_busy = busy_ff - 1'b1;
            if (busy_ff == 1) begin
                nxt_prog_ready = 1'b1;
            end
        end
        if (!sp_enable) begin
            nxt_prog_ready = 1'b0;
            nxt_busy = '0;
        end else if (!sp_d_ff) begin
            // defaults unless the retain bit is set
            if (!prog_retain) begin
                for (int i = 0; i < 32; i++) begin
                    nxt_mem[i] = 14'h0000;
                end
                nxt_mem[tsp_pkg::SLOT_FS_LO] = {6'h00, tsp_pkg::FRAME_SYNC_DEF[7:0]};
                nxt_mem[tsp_pkg::SLOT_FS_HI] = {6'h00, tsp_pkg::FRAME_SYNC_DEF[15:8]};
                nxt_mem[tsp_pkg::SLOT_BS_LO] = {6'h00, tsp_pkg::BIT_SYNC_DEF[7:0]};
                nxt_mem[tsp_pkg::SLOT_BS_HI] = {6'h00, tsp_pkg::BIT_SYNC_DEF[15:8]};
            end
            nxt_prog_ready = 1'b0;
            nxt_busy = PROG_CYCLES[tsp_pkg::BUSY_W-1:0];
        end else if (wr_ok) begin
            // only an accepted write, or sp_enable low, clears the flag
            nxt_prog_ready = 1'b0;
            nxt_busy = PROG_CYCLES[tsp_pkg::BUSY_W-1:0];
            // pointer restarts on a first word
            nxt_ptr = wr_data_ff[tsp_pkg::FIRST_BIT] ? 4'h0 : ((ptr_ff == 4'hF) ? ptr_ff : ptr_ff + 4'h1);
            // words past the block count are ignored
            if (nxt_ptr < limit) begin
                nxt_mem[{blk, nxt_ptr[2:0]}] = (blk == 2'h0) ? (data & tsp_pkg::B0_DATA_MASK) : data;
            end
        end
    end

    // Pattern and tone outputs are re-registered from the store each cycle
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 32; i++) begin
                mem_ff[i] <= 14'h0000;
            end
            prog_ready_ff <= 1'b0;
            busy_ff <= '0;
            ptr_ff <= 4'h0;
            sp_d_ff <= 1'b0;
            fs_ff <= tsp_pkg::FRAME_SYNC_DEF;
            bs_ff <= tsp_pkg::BIT_SYNC_DEF;
            tlen_ff <= tsp_pkg::TLEN_0;
            deemph_ff <= 1'b0;
        end else begin
            for (int i = 0; i < 32; i++) begin
                mem_ff[i] <= nxt_mem[i];
            end
            prog_ready_ff <= nxt_prog_ready;
            busy_ff <= nxt_busy;
            ptr_ff <= nxt_ptr;
            sp_d_ff <= sp_enable;
            fs_ff <= {mem_ff[tsp_pkg::SLOT_FS_HI][7:0], mem_ff[tsp_pkg::SLOT_FS_LO][7:0]};
            bs_ff <= {mem_ff[tsp_pkg::SLOT_BS_HI][7:0], mem_ff[tsp_pkg::SLOT_BS_LO][7:0]};
            tlen_ff <= tone_len(mem_ff[tsp_pkg::SLOT_B1W1][tsp_pkg::TLEN_LSB +: 2]);
            deemph_ff <= mem_ff[tsp_pkg::SLOT_B1W0][0];
        end
    end

    assign ser_dout = dout_ff;
    assign ser_dout_oe_n = oe_n_ff;
    assign prog_ready = prog_ready_ff;
    assign ctcss_evt = ctcss_evt_ff;
    assign dcs_evt = dcs_evt_ff;
    assign inband_evt = inband_evt_ff;
    assign frame_sync_pattern = fs_ff;
    assign bit_sync_pattern = bs_ff;
    assign tone_len_ms = tlen_ff;
    assign inband_deemph_en = deemph_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_quiet_invalid;
        ($past(word_ff[5:0]) == tsp_pkg::SUB_NONE) && (word_ff[5:0] == tsp_pkg::SUB_INVALID)
            && $stable(word_ff[10:8]) |-> !ctcss_evt_ff;
    endproperty
    a_quiet_invalid: assert property (p_quiet_invalid) else $error("invalid tone from none raised event");
    property p_low_blank;
        word_ff[10:8] != tsp_pkg::COND_NONE |-> word_ff[7:0] == 8'h00;
    endproperty
    a_low_blank: assert property (p_low_blank) else $error("low byte not blank under condition");
    property p_tx_zero;
        tx_mode |=> word_ff == 16'h0000 && !ctcss_evt_ff && !dcs_evt_ff;
    endproperty
    a_tx_zero: assert property (p_tx_zero) else $error("status not zero in transmit");
    property p_inb_evt;
        !tx_mode && word_ff[15:11] != nxt_word[15:11] && nxt_word[15:11] != INB_UNRECOG
            && word_ff[15:11] != INB_UNRECOG |=> inband_evt_ff;
    endproperty
    a_inb_evt: assert property (p_inb_evt) else $error("in-band change missed");
    property p_dcs_evt;
        // Entering a DCS code blanks the sub index, and that change may flag too
        !tx_mode && is_dcs(nxt_word[10:8]) && nxt_word[10:8] != word_ff[10:8]
            |=> dcs_evt_ff && (!ctcss_evt_ff || $past(word_ff[5:0]) != word_ff[5:0]);
    endproperty
    a_dcs_evt: assert property (p_dcs_evt) else $error("DCS condition change missed");
    property p_wr_clears;
        wr_ok |=> !prog_ready_ff ##1 !prog_ready_ff;
    endproperty
    a_wr_clears: assert property (p_wr_clears) else $error("ready not cleared by write");
    property p_ready_back;
        busy_ff == 1 && sp_enable |=> prog_ready_ff && busy_ff == 0;
    endproperty
    a_ready_back: assert property (p_ready_back) else $error("ready not restored");
    property p_ready_holds;
        prog_ready_ff && !wr_stb_ff && sp_enable |=> prog_ready_ff;
    endproperty
    a_ready_holds: assert property (p_ready_holds) else $error("ready dropped without write");
    property p_b0_store;
        wr_ok && wr_data_ff[15:12] == 4'hC |=> ##1 fs_ff[7:0] == $past(wr_data_ff[7:0], 2);
    endproperty
    a_b0_store: assert property (p_b0_store) else $error("block 0 first word not stored");
    c_write: cover property (wr_ok);
    c_dcs: cover property (dcs_evt_ff);
    c_read: cover property ($fell(oe_n_ff));
endmodule
`default_nettype wire

/* pkg/tsp_pkg.sv */
// Constants for the tone status word and the configuration load port
package tsp_pkg;
    // Register offsets on the serial control bus
    localparam logic [7:0] PROG_OFS = 8'hC8;
    localparam logic [7:0] TONE_OFS = 8'hCC;
    // Serial frame: 8 address bits then 16 data bits
    localparam logic [4:0] ADDR_BITS = 5'h08;
    localparam logic [4:0] FIRST_OUT = 5'h09;
    localparam logic [4:0] LAST_BIT = 5'h17;
    localparam logic [4:0] END_BITS = 5'h18;
    // Tone status word fields
    localparam int SUB_LSB = 0;
    localparam int COND_LSB = 8;
    localparam int INB_LSB = 11;
    localparam logic [5:0] SUB_NONE = 6'h00;
    localparam logic [5:0] SUB_INVALID = 6'h37;
    localparam logic [4:0] INB_NONE = 5'h00;
    localparam logic [2:0] COND_NONE = 3'h0;
    localparam logic [2:0] COND_DCS = 3'h2;
    localparam logic [2:0] COND_DCS_INV = 3'h3;
    localparam logic [2:0] COND_TURNOFF = 3'h5;
    localparam logic [2:0] COND_EXT = 3'h6;
    // Programming word fields
    localparam int FIRST_BIT = 15;
    localparam int BLK_SEL_BIT = 14;
    localparam int TLEN_LSB = 10;
    localparam logic [1:0] BLK_RSVD = 2'h3;
    localparam logic [1:0] BLK4_SLOT = 2'h3;
    localparam logic [3:0] B0_WORDS = 4'h8;
    localparam logic [3:0] B1_WORDS = 4'h6;
    localparam logic [3:0] B2_WORDS = 4'h5;
    localparam logic [3:0] B4_WORDS = 4'h8;
    localparam logic [13:0] B0_DATA_MASK = 14'h00FF;
    // Storage slots, {block slot, word pointer}
    localparam logic [4:0] SLOT_FS_LO = 5'h00;
    localparam logic [4:0] SLOT_FS_HI = 5'h01;
    localparam logic [4:0] SLOT_BS_LO = 5'h06;
    localparam logic [4:0] SLOT_BS_HI = 5'h07;
    localparam logic [4:0] SLOT_B1W0 = 5'h08;
    localparam logic [4:0] SLOT_B1W1 = 5'h09;
    // Default values loaded when signal processing leaves reset
    localparam logic [15:0] FRAME_SYNC_DEF = 16'hCB23;
    localparam logic [15:0] BIT_SYNC_DEF = 16'h5555;
    // Tone lengths in ms for codes 00..11
    localparam logic [6:0] TLEN_0 = 7'h28;
    localparam logic [6:0] TLEN_1 = 7'h3C;
    localparam logic [6:0] TLEN_2 = 7'h50;
    localparam logic [6:0] TLEN_3 = 7'h64;
    // Programming action time
    localparam int PROG_TIME_NS = 250000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int BUSY_W = 13;
endpackage

/* test/tsp_host_model.sv */
// Host controller model for the serial control bus and the load handshake
`timescale 1ns/1ps
`default_nettype none
module tsp_host_model (
    input wire logic ref_clk,
    input wire logic ser_dout,
    input wire logic ser_dout_oe_n,
    input wire logic prog_ready,
    output logic ser_clk,
    output logic ser_csel_n,
    output logic ser_din,
    output logic oe_seen
);
    // Bus clock stands low between frames, select released
    initial begin
        ser_clk = 1'b0;
        ser_csel_n = 1'b1;
        ser_din = 1'b1;
        oe_seen = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // One frame, 8 address then 16 data bits, MSB first, 320 ns a bit
    task automatic xfer(input logic [7:0] addr, input logic [15:0] wd, output logic [15:0] rd);
        logic [23:0] sh;
        sh = {addr, wd};
        rd = 16'h0000;
        oe_seen = 1'b0;
        @(negedge ref_clk);
        ser_csel_n = 1'b0;
        for (int i = 0; i < 24; i++) begin
            ser_din = sh[23 - i];
            repeat (4) @(negedge ref_clk);
            ser_clk = 1'b1;
            if (i >= 8) rd = {rd[14:0], ser_dout};
            if (ser_dout_oe_n === 1'b0) oe_seen = 1'b1;
            repeat (4) @(negedge ref_clk);
            ser_clk = 1'b0;
        end
        repeat (4) @(negedge ref_clk);
        ser_csel_n = 1'b1;
        // Released data line must not keep the last bit
        ser_din = ~ser_din;
        repeat (8) @(negedge ref_clk);
    endtask
    ////////////////////////////////////////////////////////////////
    // write only with ready up
    task automatic prog(input logic [15:0] w, output logic ok);
        logic [15:0] rd;
        int n;
        n = 0;
        while (prog_ready !== 1'b1 && n < 1000) begin
            @(negedge ref_clk);
            n++;
        end
        ok = (prog_ready === 1'b1);
        if (ok) xfer(8'hC8, w, rd);
    endtask
endmodule
`default_nettype wire

/* test/tsp_tone_prog_tb.sv */
// Self-checking bench for tone status word and configuration load port
`timescale 1ns/1ps
`default_nettype none
module tsp_tone_prog_tb;
    // Short action time keeps the run brief
    localparam int PCYC = 20;
    logic ref_clk, reset, ser_clk, ser_csel_n, ser_din, ser_dout, ser_dout_oe_n, oe_seen;
    logic [5:0] sub_tone_idx;
    logic [2:0] sub_cond;
    logic [4:0] inband_idx;
    logic ctcss_en, dcs_en, ext_tone_en, inband_en, rx_mode, tx_mode;
    logic sp_enable, xtal_off, prog_retain, prog_ready, ctcss_evt, dcs_evt, inband_evt;
    logic [15:0] frame_sync_pattern, bit_sync_pattern, rd;
    logic [6:0] tone_len_ms;
    logic inband_deemph_en;
    logic [6:0] tl [4] = '{7'h28, 7'h3C, 7'h50, 7'h64};
    logic [2:0] cl [4] = '{3'h2, 3'h3, 3'h5, 3'h6};
    logic [7:0] b0 [8] = '{8'h12, 8'h34, 8'hA1, 8'hB2, 8'hC3, 8'hD4, 8'h5A, 8'hA5};
    int failures = 0;
    int n_compared = 0;
    int n_ct, n_dc, n_ib;
    tsp_tone_prog #(.PROG_CYCLES(PCYC)) u_dut (.ref_clk(ref_clk), .reset(reset), .ser_clk(ser_clk),
        .ser_csel_n(ser_csel_n), .ser_din(ser_din), .ser_dout(ser_dout), .ser_dout_oe_n(ser_dout_oe_n),
        .sub_tone_idx(sub_tone_idx), .sub_cond(sub_cond), .inband_idx(inband_idx), .ctcss_en(ctcss_en),
        .dcs_en(dcs_en), .ext_tone_en(ext_tone_en), .inband_en(inband_en), .rx_mode(rx_mode),
        .tx_mode(tx_mode), .sp_enable(sp_enable), .xtal_off(xtal_off), .prog_retain(prog_retain),
        .prog_ready(prog_ready), .ctcss_evt(ctcss_evt), .dcs_evt(dcs_evt), .inband_evt(inband_evt),
        .frame_sync_pattern(frame_sync_pattern), .bit_sync_pattern(bit_sync_pattern),
        .tone_len_ms(tone_len_ms), .inband_deemph_en(inband_deemph_en));
    tsp_host_model u_host (.ref_clk(ref_clk), .ser_dout(ser_dout), .ser_dout_oe_n(ser_dout_oe_n),
        .prog_ready(prog_ready), .ser_clk(ser_clk), .ser_csel_n(ser_csel_n), .ser_din(ser_din),
        .oe_seen(oe_seen));
    // 25 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // Event pulse counters
    always @(posedge ref_clk) begin
        if (ctcss_evt === 1'b1) n_ct++;
        if (dcs_evt === 1'b1) n_dc++;
        if (inband_evt === 1'b1) n_ib++;
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Load one word; ready must drop once it is taken
    task automatic pw(input logic [15:0] w);
        logic ok;
        u_host.prog(w, ok);
        chk({15'h0000, ok}, 16'h0001);
        chk({15'h0000, prog_ready}, 16'h0000);
    endtask
    // Detector step and the event pulses it should give
    task automatic ev(input logic [5:0] s, input logic [2:0] c, input logic [4:0] b, input logic [2:0] e);
        n_ct = 0;
        n_dc = 0;
        n_ib = 0;
        sub_tone_idx = s;
        sub_cond = c;
        inband_idx = b;
        repeat (4) @(negedge ref_clk);
        chk({4'h0, 4'(n_ct), 4'(n_dc), 4'(n_ib)}, {7'h00, e[2], 3'h0, e[1], 3'h0, e[0]});
    endtask
    // Detector state, then a status word read over the bus
    task automatic st(input logic [5:0] s, input logic [2:0] c, input logic [4:0] b, input logic [3:0] en,
        input logic tx, input logic [15:0] exp);
        {ctcss_en, dcs_en, ext_tone_en, inband_en} = en;
        tx_mode = tx;
        sub_tone_idx = s;
        sub_cond = c;
        inband_idx = b;
        repeat (3) @(negedge ref_clk);
        u_host.xfer(8'hCC, 16'h0000, rd);
        chk(rd, exp);
        chk({15'h0000, prog_ready}, 16'h0001);
    endtask
    ////////////////////////////////////////////////////////////////
    // Watchdog, well beyond the expected run
    initial begin
        #3000000;
        failures++;
        give_verdict();
    end
    // Main sequence
    initial begin
        reset = 1'b1;
        {sub_tone_idx, sub_cond, inband_idx} = 14'h0000;
        {ctcss_en, dcs_en, ext_tone_en, inband_en, rx_mode, tx_mode} = 6'h00;
        {sp_enable, xtal_off, prog_retain} = 3'h0;
        repeat (2) @(negedge ref_clk);
        reset = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk({15'h0000, prog_ready}, 16'h0000);
        sp_enable = 1'b1;
        repeat (PCYC + 4) @(negedge ref_clk);
        chk(frame_sync_pattern, 16'hCB23);
        chk(bit_sync_pattern, 16'h5555);
        chk({15'h0000, prog_ready}, 16'h0001);
        $display("Test defaults done");
        // whole block 0 in order, detectors quiet
        for (int i = 0; i < 8; i++) pw((i == 0 ? 16'hC000 : 16'h4000) | {8'h00, b0[i]});
        chk(frame_sync_pattern, 16'h3412);
        chk(bit_sync_pattern, 16'hA55A);
        pw(16'hF077);
        pw(16'h8077);
        pw(16'h0077);
        repeat (PCYC + 4) @(negedge ref_clk);
        chk(frame_sync_pattern, 16'h3412);
        // Receive mode set: the write must be dropped
        rx_mode = 1'b1;
        u_host.xfer(8'hC8, 16'hC0EE, rd);
        chk({15'h0000, prog_ready}, 16'h0001);
        chk(frame_sync_pattern, 16'h3412);
        rx_mode = 1'b0;
        $display("Test block 0 done");
        // block 1 cut short after its second word
        pw(16'hD001);
        repeat (4) @(negedge ref_clk);
        chk({15'h0000, inband_deemph_en}, 16'h0001);
        for (int c = 0; c < 4; c++) begin
            pw(16'hD000);
            pw(16'h5000 | (16'(c) << 10));
            chk({9'h000, tone_len_ms}, {9'h000, tl[c]});
        end
        chk({15'h0000, inband_deemph_en}, 16'h0000);
        repeat (PCYC + 4) @(negedge ref_clk);
        $display("Test block 1 done");
        {ctcss_en, dcs_en, ext_tone_en, inband_en} = 4'hF;
        ev(6'h37, 3'h0, 5'h00, 3'h0);
        ev(6'h05, 3'h0, 5'h00, 3'h4);
        ev(6'h05, 3'h0, 5'h03, 3'h1);
        ev(6'h05, 3'h0, 5'h00, 3'h1);
        ev(6'h05, 3'h0, 5'h1F, 3'h0);
        ev(6'h05, 3'h0, 5'h00, 3'h0);
        ev(6'h00, 3'h0, 5'h00, 3'h4);
        ev(6'h00, 3'h2, 5'h00, 3'h2);
        ev(6'h00, 3'h0, 5'h00, 3'h2);
        ev(6'h00, 3'h6, 5'h00, 3'h4);
        ev(6'h00, 3'h0, 5'h00, 3'h4);
        $display("Test events done");
        st(6'h05, 3'h0, 5'h03, 4'hF, 1'b0, 16'h1805);
        chk({15'h0000, oe_seen}, 16'h0001);
        st(6'h37, 3'h0, 5'h00, 4'hF, 1'b0, 16'h0037);
        for (int k = 0; k < 4; k++) st(6'h05, cl[k], 5'h03, 4'hF, 1'b0, {5'h03, cl[k], 8'h00});
        st(6'h05, 3'h0, 5'h03, 4'h7, 1'b0, 16'h1800);
        st(6'h05, 3'h0, 5'h03, 4'hE, 1'b0, 16'h0005);
        st(6'h00, 3'h6, 5'h00, 4'hD, 1'b0, 16'h0000);
        st(6'h05, 3'h0, 5'h03, 4'hF, 1'b1, 16'h0000);
        // Crystal off: the write must be dropped
        tx_mode = 1'b0;
        xtal_off = 1'b1;
        u_host.xfer(8'hC8, 16'hC0EE, rd);
        chk({15'h0000, prog_ready}, 16'h0001);
        chk(frame_sync_pattern, 16'h3412);
        xtal_off = 1'b0;
        // Processing restart keeps the store with retain set, else defaults
        for (int r = 1; r >= 0; r--) begin
            prog_retain = 1'(r);
            sp_enable = 1'b0;
            repeat (2) @(negedge ref_clk);
            sp_enable = 1'b1;
            repeat (PCYC + 4) @(negedge ref_clk);
            chk(frame_sync_pattern, (r == 1) ? 16'h3412 : 16'hCB23);
            chk({15'h0000, prog_ready}, 16'h0001);
        end
        // Unmapped address leaves the read line released
        u_host.xfer(8'h55, 16'h0000, rd);
        chk({15'h0000, oe_seen}, 16'h0000);
        $display("Test status done");
        give_verdict();
    end
endmodule
`default_nettype wire
